// ### logic/alarm_flag_bank.sv
// sixteen sticky alarm flags, four per channel, cleared by a host read
// assumes: conditions are synchronous to core_clk; clear is a one-cycle mask
`timescale 1ns/1ps
`include "quad_line_if_regs.svh"

module alarm_flag_bank (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        softReset,
    input  wire logic [15:0] alarmCond,
    input  wire logic [15:0] clearMask,
    output logic      [15:0] flags
);
    import quad_line_if_pkg::*;

    flags_s s;
    flags_s n;

    // a live condition always wins over the read clear, so it never drops
    always_comb begin
        n.flags = (s.flags & ~clearMask) | alarmCond;
        if (rst || softReset) begin
            n.flags = 16'h0000;
        end
    end

    always_ff @(posedge core_clk) begin
        s <= n;
    end

    assign flags = s.flags;

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst || softReset);

    a_flag_persists: assert property (
        (clearMask & alarmCond) != 16'h0000
        |=> (flags & $past(clearMask & alarmCond)) == $past(clearMask & alarmCond))
        else $error("persistent alarm lost on read");

    a_flag_clears: assert property (
        (clearMask != 16'h0000) && (alarmCond == 16'h0000)
        |=> (flags & $past(clearMask)) == 16'h0000)
        else $error("ended alarm not cleared by read");

endmodule // alarm_flag_bank

// ### logic/quad_line_if_pkg.sv
// types shared by the line interface register bank and its alarm flags
// assumes: offsets and fields come from quad_line_if_regs.svh
package quad_line_if_pkg;

    // host access sequencer; idle->read and idle->write each flip one bit
    typedef enum logic [1:0] {
        BUS_IDLE  = 2'b00,
        BUS_READ  = 2'b01,
        BUS_WRITE = 2'b10
    } bus_state_e;

    typedef struct packed {
        bus_state_e  bus;
        logic [3:0]  addr;
        logic [7:0]  rdData;
        logic        adOe;
        logic        rdy;
        logic        intr;
        logic [15:0] supp;
        logic [7:0]  ctrlA;
        logic [7:0]  ctrlB;
        logic [31:0] chanCfg;
        logic [15:0] mustClear;
    } bank_s;

    typedef struct packed {
        logic [15:0] flags;
    } flags_s;

endpackage

// ### logic/quad_line_if_register_bank.sv
// register bank of a four-channel line interface behind an 8-bit host port
// assumes: host pins already synchronous to core_clk; the testbench resolves
// the data bus wire from adOut and adOe
`timescale 1ns/1ps
`include "quad_line_if_regs.svh"

module quad_line_if_register_bank (
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    input  wire logic                      csN,
    input  wire logic                      rdN,
    input  wire logic                      wrN,
    input  wire logic [3:0]                addr,
    input  wire logic [7:0]                adIn,
    output logic      [7:0]                adOut,
    output logic                           adOe,
    output logic                           rdy,
    output logic                           interrupt,
    input  wire logic [15:0]               alarmCond,
    output logic      [7:0]                globalControlA,
    output logic      [7:0]                globalControlB,
    output logic      [31:0]               channelConfig
);
    import quad_line_if_pkg::*;

    quad_line_if_pkg::bank_s s;
    quad_line_if_pkg::bank_s n;
    logic [15:0] alarmFlags;
    logic [15:0] clearMask;
    logic        readStart;
    logic        writeStart;

    // expand each channel's suppress bit over its four alarm flags
    function automatic logic [15:0] chanBlock(input logic [31:0] cfg);
        logic [15:0] m;
        m = 16'h0000;
        for (int c = 0; c < 4; c++) begin
            m[c*4 +: 4] = {4{cfg[c*8 + `QL_CC_SUPPRESS]}};
        end
        return m;
    endfunction

    // flags that may still raise the interrupt
    function automatic logic [15:0] liveAlarms(input logic [15:0] f,
                                               input bank_s b);
        logic [15:0] m;
        m = f & ~b.supp & ~chanBlock(b.chanCfg);
        if (b.ctrlA[`QL_GA_SUPPRESS]) begin
            m = 16'h0000;
        end
        return m;
    endfunction

    // read data for one address; reserved space reads as zero
    function automatic logic [7:0] readMux(input logic [3:0] a,
                                           input logic [15:0] f,
                                           input bank_s b);
        logic [7:0] d;
        d = 8'h00;
        case (a)
            `QL_ADDR_ALARM_CH12: d = f[7:0];
            `QL_ADDR_ALARM_CH34: d = f[15:8];
            `QL_ADDR_SUPP_CH12:  d = b.supp[7:0];
            `QL_ADDR_SUPP_CH34:  d = b.supp[15:8];
            `QL_ADDR_GLOBAL_A:   d = b.ctrlA;
            `QL_ADDR_GLOBAL_B:   d = b.ctrlB;
            4'h6, 4'h7, 4'h8, 4'h9: d = b.chanCfg[(a - `QL_ADDR_CHAN1)*8 +: 8];
            `QL_ADDR_CLEAR_A:    d = b.mustClear[7:0];
            `QL_ADDR_CLEAR_B:    d = b.mustClear[15:8];
            default:             d = 8'h00;
        endcase
        return d;
    endfunction

    assign readStart  = (s.bus == BUS_IDLE) && !csN && !rdN;
    assign writeStart = (s.bus == BUS_IDLE) && !csN && !wrN && rdN;

    // clear-on-read fires once, as the read strobe ends; only flags the
    // host actually saw are cleared, so an alarm rising mid-read survives
    always_comb begin
        clearMask = 16'h0000;
        if (s.bus == BUS_READ && (rdN || csN)) begin
            if (s.addr == `QL_ADDR_ALARM_CH12) begin
                clearMask = {8'h00, s.rdData};
            end else if (s.addr == `QL_ADDR_ALARM_CH34) begin
                clearMask = {s.rdData, 8'h00};
            end
        end
    end

    alarm_flag_bank flagBank (
        .core_clk  (core_clk),
        .rst       (rst),
        .softReset (s.ctrlA[`QL_GA_SOFT_RESET]),
        .alarmCond (alarmCond),
        .clearMask (clearMask),
        .flags     (alarmFlags)
    );

    // host access sequencer and register updates
    always_comb begin
        n = s;
        case (s.bus)
            BUS_IDLE: begin
                if (readStart) begin
                    n.bus    = BUS_READ;
                    n.addr   = addr;
                    n.rdData = readMux(addr, alarmFlags, s);
                    n.adOe   = 1'b1;
                    n.rdy    = 1'b1;
                end else if (writeStart) begin
                    n.bus  = BUS_WRITE;
                    n.addr = addr;
                    n.rdy  = 1'b1;
                    // alarm and reserved addresses fall to default: ignored
                    case (addr)
                        `QL_ADDR_SUPP_CH12: n.supp[7:0]  = adIn;
                        `QL_ADDR_SUPP_CH34: n.supp[15:8] = adIn;
                        `QL_ADDR_GLOBAL_A:  n.ctrlA = adIn;
                        `QL_ADDR_GLOBAL_B:  n.ctrlB = adIn;
                        4'h6, 4'h7, 4'h8, 4'h9:
                            n.chanCfg[(addr - `QL_ADDR_CHAN1)*8 +: 8] = adIn;
                        `QL_ADDR_CLEAR_A:   n.mustClear[7:0]  = adIn;
                        `QL_ADDR_CLEAR_B:   n.mustClear[15:8] = adIn;
                        default:            n.addr = addr;
                    endcase
                end
            end
            BUS_READ: begin
                if (rdN || csN) begin
                    n.bus  = BUS_IDLE;
                    n.adOe = 1'b0;
                    n.rdy  = 1'b0;
                end
            end
            BUS_WRITE: begin
                // one store per strobe; a held strobe does not rewrite
                if (wrN || csN) begin
                    n.bus = BUS_IDLE;
                    n.rdy = 1'b0;
                end
            end
            default: begin
                n.bus  = BUS_IDLE;
                n.adOe = 1'b0;
                n.rdy  = 1'b0;
            end
        endcase
        // soft reset holds the bank at reset values until software drops it
        if (n.ctrlA[`QL_GA_SOFT_RESET]) begin
            n.supp      = 16'h0000;
            n.ctrlB     = `QL_REG_RESET;
            n.chanCfg   = 32'h0000_0000;
            n.mustClear = 16'h0000;
            n.ctrlA     = `QL_GA_RESET;
            n.ctrlA[`QL_GA_SOFT_RESET] = 1'b1;
        end
        n.intr = |liveAlarms(alarmFlags, s);
        if (rst) begin
            n.bus       = BUS_IDLE;
            n.addr      = 4'h0;
            n.rdData    = 8'h00;
            n.adOe      = 1'b0;
            n.rdy       = 1'b0;
            n.intr      = 1'b0;
            n.supp      = 16'h0000;
            n.ctrlA     = `QL_GA_RESET;
            n.ctrlB     = `QL_REG_RESET;
            n.chanCfg   = 32'h0000_0000;
            n.mustClear = 16'h0000;
        end
    end

    always_ff @(posedge core_clk) begin
        s <= n;
    end

    // every output straight from the state register
    assign adOut          = s.rdData;
    assign adOe           = s.adOe;
    assign rdy            = s.rdy;
    assign interrupt      = s.intr;
    assign globalControlA = s.ctrlA;
    assign globalControlB = s.ctrlB;
    assign channelConfig  = s.chanCfg;

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence seqAlarmRead;
        readStart && (addr == `QL_ADDR_ALARM_CH12);
    endsequence

    sequence seqCfgWrite;
        writeStart && (addr >= `QL_ADDR_CHAN1) && (addr <= `QL_ADDR_CHAN4)
            && !s.ctrlA[`QL_GA_SOFT_RESET];
    endsequence

    a_alarm_read_data: assert property (
        seqAlarmRead |=> adOe && rdy && (adOut == $past(alarmFlags[7:0])))
        else $error("alarm read returned wrong flags");

    a_alarm_write_ro: assert property (
        writeStart && (addr <= `QL_ADDR_ALARM_CH34) && (alarmCond == 16'h0000)
        |=> alarmFlags == $past(alarmFlags))
        else $error("write altered alarm flags");

    a_supp_write: assert property (
        writeStart && (addr == `QL_ADDR_SUPP_CH34)
            && !s.ctrlA[`QL_GA_SOFT_RESET]
        |=> s.supp[15:8] == $past(adIn))
        else $error("suppress write not stored");

    a_masked_quiet: assert property (
        ((alarmFlags & ~s.supp & ~chanBlock(s.chanCfg)) == 16'h0000)
        |=> !interrupt)
        else $error("suppressed flag raised interrupt");

    a_reset_values: assert property (
        $fell(rst) |-> (globalControlA == `QL_GA_RESET)
            && (globalControlB == `QL_REG_RESET) && !interrupt && !adOe)
        else $error("wrong reset values");

    a_ctrlb_write: assert property (
        writeStart && (addr == `QL_ADDR_GLOBAL_B)
            && !s.ctrlA[`QL_GA_SOFT_RESET]
        |=> ((globalControlB == $past(adIn)) && rdy)
            ##1 (globalControlB == $past(adIn, 2)))
        else $error("global control b write not stored");

    a_chan_write: assert property (
        seqCfgWrite |=> channelConfig[($past(addr) - `QL_ADDR_CHAN1)*8 +: 8]
            == $past(adIn))
        else $error("channel config write not stored");

    a_global_quiet: assert property (
        s.ctrlA[`QL_GA_SUPPRESS] [*2] |-> !interrupt)
        else $error("interrupt under global suppress");

    a_intr_raise: assert property (
        !s.ctrlA[`QL_GA_SUPPRESS]
            && ((alarmFlags & ~s.supp & ~chanBlock(s.chanCfg)) != 16'h0000)
        |=> interrupt)
        else $error("live alarm did not raise interrupt");

endmodule // quad_line_if_register_bank

// ### logic/quad_line_if_regs.svh
// register offsets, field positions, reset values of the line interface bank
// assumes: included by bare name from the two modules
`ifndef QUAD_LINE_IF_REGS_SVH
`define QUAD_LINE_IF_REGS_SVH

// register offsets on the 4-bit address
`define QL_ADDR_ALARM_CH12    4'h0
`define QL_ADDR_ALARM_CH34    4'h1
`define QL_ADDR_SUPP_CH12     4'h2
`define QL_ADDR_SUPP_CH34     4'h3
`define QL_ADDR_GLOBAL_A      4'h4
`define QL_ADDR_GLOBAL_B      4'h5
`define QL_ADDR_CHAN1         4'h6
`define QL_ADDR_CHAN4         4'h9
`define QL_ADDR_CLEAR_A       4'hA
`define QL_ADDR_CLEAR_B       4'hB
`define QL_ADDR_RSVD_BASE     4'hC

// alarm order within each channel nibble
`define QL_ALM_ANALOG_LOSS    0
`define QL_ALM_DIGITAL_LOSS   1
`define QL_ALM_DRIVER_MON     2
`define QL_ALM_TXCLK_LOSS     3

// global control a fields
`define QL_GA_SUPPRESS        0
`define QL_GA_SOFT_RESET      1
`define QL_GA_LOSS_STD        2
`define QL_GA_TEST_PIN        3
`define QL_GA_FLOAT_LSB       4

// global control b fields
`define QL_GB_CLK_RECOVERY    0
`define QL_GB_RX_JITTER       1
`define QL_GB_TX_JITTER       2
`define QL_GB_ZERO_SUBST      3
`define QL_GB_RAIL_MODE       4
`define QL_GB_POLARITY        5
`define QL_GB_RX_EDGE         6
`define QL_GB_LOSS_SHUTDOWN   7

// channel configuration fields
`define QL_CC_POWER_OFF       0
`define QL_CC_SUPPRESS        1
`define QL_CC_ALL_ONES        2
`define QL_CC_LPBK_LSB        3
`define QL_CC_EQ_LSB          5

// reset values: suppress on, test pin function 0, all drivers floated
`define QL_GA_RESET           8'hF1
`define QL_REG_RESET          8'h00

`endif

// ### sim/host_cpu_model.sv
// host processor model: register reads and writes on the bank's host port
// assumes: strobes change at the falling edge, acknowledge sampled at the falling edge
`timescale 1ns/1ps

module host_cpu_model (
    input  wire logic       core_clk,
    output logic            csN,
    output logic            rdN,
    output logic            wrN,
    output logic [3:0]      addr,
    output logic [7:0]      adIn,
    input  wire logic [7:0] adOut,
    input  wire logic       adOe,
    input  wire logic       rdy,
    output logic            hung
);
    // idle bus at time zero, no strobe asserted
    initial begin
        csN = 1'b1;
        rdN = 1'b1;
        wrN = 1'b1;
        addr = 4'h0;
        adIn = 8'h00;
        hung = 1'b0;
    end

    // one register access; the request holds until rdy is sampled high
    task automatic access(input logic wr, input logic [3:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        int n;
        logic [7:0] dat;
        dat = (a >= 4'hC) ? 8'h00 : d;
        @(negedge core_clk);
        csN = 1'b0;
        addr = a;
        rdN = wr;
        wrN = ~wr;
        adIn = dat;
        n = 0;
        // look at rdy where it is settled; the request then still stands
        // across the rising edge that samples rdy high
        do begin
            @(negedge core_clk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        if (n >= 20) begin
            hung = 1'b1;
        end
        // a bus nobody drives reads as unknown, so it can never match
        q = (adOe === 1'b1) ? adOut : 8'hXX;
        @(negedge core_clk);
        csN = 1'b1;
        rdN = 1'b1;
        wrN = 1'b1;
        adIn = ~dat; // released data lines: show the inverse, not the old value
        addr = ~a;
        // the strobe stays high three cycles before the next access; the bank needs one
        repeat (2) @(negedge core_clk);
    endtask
endmodule // host_cpu_model

// ### sim/quad_line_if_register_bank_tb.sv
// self-checking bench of the line interface register bank
// assumes: host model drives the register port, bench drives alarm inputs
`timescale 1ns/1ps

module quad_line_if_register_bank_tb;
    logic        core_clk;
    logic        rst;
    logic        csN, rdN, wrN, adOe, rdy, interrupt, hung;
    logic [3:0]  addr;
    logic [7:0]  adIn, adOut, globalControlA, globalControlB;
    logic [15:0] alarmCond;
    logic [31:0] channelConfig;
    int          miscompares = 0;
    int          checks = 0;
    int          cycles = 0;
    int          seed;

    quad_line_if_register_bank DUT (.core_clk(core_clk), .rst(rst),
        .csN(csN), .rdN(rdN), .wrN(wrN), .addr(addr), .adIn(adIn),
        .adOut(adOut), .adOe(adOe), .rdy(rdy), .interrupt(interrupt),
        .alarmCond(alarmCond), .globalControlA(globalControlA),
        .globalControlB(globalControlB), .channelConfig(channelConfig));

    host_cpu_model host (.core_clk(core_clk), .csN(csN), .rdN(rdN),
        .wrN(wrN), .addr(addr), .adIn(adIn), .adOut(adOut), .adOe(adOe),
        .rdy(rdy), .hung(hung));

    // 125 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic final_report();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chkBit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        host.access(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] q);
        host.access(1'b0, a, 8'h00, q);
    endtask

    // hang guard: the whole run needs about a thousand cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000 || hung === 1'b1) begin
            miscompares++;
            final_report();
        end
    end

    initial begin
        logic [7:0] q, v;
        logic [7:0] cfg [0:15];
        logic [1:0] mode;
        int         ch;
        seed = 71172;
        rst = 1'b1;
        alarmCond = 16'h0000;
        repeat (8) @(negedge core_clk);
        rst = 1'b0;
        // reset values at the ports and through the host port
        chk8(globalControlA, 8'hF1);
        chk8(globalControlB, 8'h00);
        chkBit(interrupt, 1'b0);
        for (int r = 0; r < 16; r++) begin
            rd(r[3:0], q);
            chk8(q, (r == 4) ? 8'hF1 : 8'h00);
        end
        // host bring-up, then random configuration of the suppress, global and channel registers
        wr(4'hA, 8'h00);
        wr(4'hB, 8'h00);
        wr(4'hC, 8'h5A);
        for (int r = 0; r < 16; r++) begin
            cfg[r] = 8'h00;
        end
        for (int r = 2; r < 10; r++) begin
            v = 8'($random(seed));
            if (r == 4) begin
                v[1] = 1'b0; // keep out of soft reset
            end
            cfg[r] = v;
            wr(r[3:0], v);
        end
        wr(4'h0, 8'hFF);
        wr(4'h1, 8'hFF);
        for (int r = 0; r < 16; r++) begin
            rd(r[3:0], q);
            chk8(q, cfg[r]);
        end
        chk8(globalControlA, cfg[4]);
        chk8(globalControlB, cfg[5]);
        for (int c = 0; c < 4; c++) begin
            chk8(channelConfig[8*c +: 8], cfg[6+c]);
        end
        // soft reset holds the bank at reset values and drops writes
        wr(4'h4, 8'h02);
        wr(4'h5, 8'h55);
        rd(4'h4, q);
        chk8(q, 8'hF3);
        rd(4'h5, q);
        chk8(q, 8'h00);
        wr(4'h4, 8'h00);
        // each alarm with a random suppress mode: none, own, channel, global
        for (int i = 0; i < 16; i++) begin
            mode = 2'($random(seed));
            v = 8'($random(seed));
            ch = i / 4;
            wr(4'h2, (mode == 1 && i < 8) ? 8'h01 << i : 8'h00);
            wr(4'h3, (mode == 1 && i >= 8) ? 8'h01 << (i - 8) : 8'h00);
            wr(4'h4, {v[7:4], 1'b0, v[2], 1'b0, mode == 3});
            wr(4'(6 + ch), {v[7:2], mode == 2, v[0]});
            @(negedge core_clk);
            alarmCond[i] = 1'b1;
            repeat (3) @(negedge core_clk);
            chkBit(interrupt, mode == 0);
            wr(4'(i / 8), 8'h00);
            rd(4'(i / 8), q);
            chk8(q, 8'h01 << (i % 8));
            alarmCond[i] = 1'b0;
            rd(4'(i / 8), q);
            chk8(q, 8'h01 << (i % 8));
            rd(4'(i / 8), q);
            chk8(q, 8'h00);
            chkBit(interrupt, 1'b0);
        end
        // second reset in mid-run: configured bank returns to reset values
        wr(4'h5, 8'hA5);
        wr(4'h2, 8'hFF);
        @(negedge core_clk);
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        chk8(globalControlA, 8'hF1);
        chk8(globalControlB, 8'h00);
        chkBit(channelConfig == 32'h0000_0000, 1'b1);
        chkBit(interrupt, 1'b0);
        rd(4'h2, q);
        chk8(q, 8'h00);
        final_report();
    end
endmodule // quad_line_if_register_bank_tb
